// ==== verilog/frf_top.sv ====
`timescale 1ns/1ps
module frf_top #(
   parameter logic [7:0] IMP_CODE = 8'h5A,   // Arbitrary value
   parameter logic [3:0] REV_MAJOR = 4'h1,
   parameter logic [3:0] REV_MINOR = 4'h0
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic REG_WIDTH_SELECT,
   input wire frf_pkg::frf_req_t FPR_RD_REQ,
   output logic [63:0] FPR_RD_DATA,
   output logic FPR_RD_VALID,
   output logic FPR_RD_BAD,
   input wire frf_pkg::frf_req_t FPR_WR_REQ,
   input wire logic [63:0] FPR_WR_DATA,
   output logic FPR_WR_BAD,
   input wire logic CTL_RD_EN,
   input wire logic [4:0] CTL_RD_NUM,
   output logic [31:0] CTL_RD_DATA,
   output logic CTL_RD_VALID,
   input wire logic CTL_WR_EN,
   input wire logic [4:0] CTL_WR_NUM,
   input wire logic [31:0] CTL_WR_DATA,
   input wire logic CMP_EN,
   input wire logic CMP_RESULT,
   input wire frf_pkg::frf_op_t OP_DONE,
   output logic [1:0] ROUND_SELECT,
   output logic DENORM_FLUSH_ENABLE,
   output logic COND,
   output logic FP_EXC,
   output logic FLUSH_TAKE,
   output logic FLUSH_MINNORM,
   output logic FLUSH_NEG
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage address mapping
   logic [1:0] wr_half [2];      // Half enables per bank
   logic [63:0] wr_bank [2];     // Write data per bank
   logic [63:0] rd_bank [2];     // Registered bank read data
   logic rd_bad;                 // Odd register with width select 0
   logic wr_bad;
   logic fpr_wr_bad_q, fpr_wr_bad_d;

   // Entry k sits in bank k[0] at row k[4:1], so a pair reads in one cycle
   always_comb begin
      wr_half[0] = 2'h0;
      wr_half[1] = 2'h0;
      wr_bank[0] = FPR_WR_DATA;
      wr_bank[1] = FPR_WR_DATA;
      wr_bad = FPR_WR_REQ.en && !FPR_WR_REQ.word && !REG_WIDTH_SELECT
         && FPR_WR_REQ.num[0];
      if (FPR_WR_REQ.en && !wr_bad) begin
         if (FPR_WR_REQ.word) begin
            // Word move touches the low half of one entry
            wr_half[FPR_WR_REQ.num[0]] = 2'h1;
         end else if (REG_WIDTH_SELECT) begin
            wr_half[FPR_WR_REQ.num[0]] = 2'h3;
         end else begin
            // Even register spans entries n and n+1
            wr_half[0] = 2'h1;
            wr_half[1] = 2'h1;
            wr_bank[1] = {32'h0, FPR_WR_DATA[63:32]};
         end
      end
      fpr_wr_bad_d = wr_bad;
   end

   // Two banks of 16 rows hold all 32 entries
   for (genvar b = 0; b < 2; b++) begin : g_bank
      frf_store #(.DEPTH(16), .AW(4), .W(64)) u_store (
         .clk(CLK),
         .rstn(RSTN),
         .wr_half(wr_half[b]),
         .wr_addr(FPR_WR_REQ.num[4:1]),
         .wr_data(wr_bank[b]),
         .rd_en(FPR_RD_REQ.en),
         .rd_addr(FPR_RD_REQ.num[4:1]),
         .rd_data_q(rd_bank[b])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read pipeline, request attributes are registered in the same cycle as the bank read
   logic p_en_q, p_en_d;
   logic p_bad_q, p_bad_d;
   logic p_word_q, p_word_d;
   logic p_wide_q, p_wide_d;
   logic p_odd_q, p_odd_d;
   logic [63:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic rbad_q, rbad_d;

   always_comb begin
      rd_bad = !FPR_RD_REQ.word && !REG_WIDTH_SELECT && FPR_RD_REQ.num[0];
      p_en_d = FPR_RD_REQ.en;
      p_bad_d = FPR_RD_REQ.en && rd_bad;
      p_word_d = FPR_RD_REQ.word;
      p_wide_d = REG_WIDTH_SELECT;
      p_odd_d = FPR_RD_REQ.num[0];
      rvalid_d = p_en_q;
      rbad_d = p_en_q && p_bad_q;
      rdata_d = rdata_q;
      if (p_en_q) begin
         if (p_bad_q) begin
            // Refused reads return zero
            rdata_d = '0;
         end else if (p_word_q) begin
            rdata_d = {32'h0, rd_bank[p_odd_q][31:0]};
         end else if (p_wide_q) begin
            rdata_d = rd_bank[p_odd_q];
         end else begin
            rdata_d = {rd_bank[1][31:0], rd_bank[0][31:0]};
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         p_en_q <= 1'b0;
         p_bad_q <= 1'b0;
         p_word_q <= 1'b0;
         p_wide_q <= 1'b0;
         p_odd_q <= 1'b0;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         rbad_q <= 1'b0;
         fpr_wr_bad_q <= 1'b0;
      end else begin
         p_en_q <= p_en_d;
         p_bad_q <= p_bad_d;
         p_word_q <= p_word_d;
         p_wide_q <= p_wide_d;
         p_odd_q <= p_odd_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         rbad_q <= rbad_d;
         fpr_wr_bad_q <= fpr_wr_bad_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control/status register
   logic [31:0] csr_q, csr_d;
   logic [31:0] id_val;
   logic wr31;                   // Control write to status register
   logic upd;                    // Class that updates cause and flags
   logic [4:0] en_f;
   logic [5:0] cause_n;
   logic exc_n;
   logic flush;
   logic ftake_q, ftake_d;
   logic fmin_q, fmin_d;
   logic fneg_q, fneg_d;
   logic exc_q, exc_d;

   // Only one register number is writable, the rest drop silently
   assign wr31 = CTL_WR_EN && (CTL_WR_NUM == frf_pkg::CTL_NUM_CSR);
   assign upd = (OP_DONE.op_class == frf_pkg::FRF_OP_COMPUTE)
      || (OP_DONE.op_class == frf_pkg::FRF_OP_CONVERT)
      || (OP_DONE.op_class == frf_pkg::FRF_OP_RESERVED);
   assign id_val = {16'h0, IMP_CODE, REV_MAJOR, REV_MINOR};

   // Control write first, then hardware updates so a hardware update beats a control write
   always_comb begin
      csr_d = csr_q;
      cause_n = OP_DONE.cause;
      flush = 1'b0;
      ftake_d = 1'b0;
      fmin_d = 1'b0;
      fneg_d = OP_DONE.neg;
      if (wr31) begin
         // No privilege check, any mode may write
         csr_d = CTL_WR_DATA & frf_pkg::CSR_WR_MASK;
      end
      en_f = csr_d[frf_pkg::CSR_EN_LSB +: 5];
      if (CMP_EN) begin
         csr_d[frf_pkg::CSR_COND_BIT] = CMP_RESULT;
      end
      if (upd && OP_DONE.denorm) begin
         if (csr_d[frf_pkg::CSR_FS_BIT] && !en_f[frf_pkg::EXC_U]
               && !en_f[frf_pkg::EXC_I]) begin
            flush = 1'b1;
            cause_n[frf_pkg::EXC_U] = 1'b1;
            cause_n[frf_pkg::EXC_I] = 1'b1;
         end else begin
            // Without flushing the result needs software emulation
            cause_n[frf_pkg::EXC_E] = 1'b1;
         end
      end
      exc_n = cause_n[frf_pkg::EXC_E] || ((cause_n[4:0] & en_f) != 5'h0);
      if (upd) begin
         csr_d[frf_pkg::CSR_CAUSE_LSB +: 6] = cause_n;
         if (!exc_n) begin
            // A trapped operation leaves flags to the handler
            csr_d[frf_pkg::CSR_FLAG_LSB +: 5] =
               csr_d[frf_pkg::CSR_FLAG_LSB +: 5] | cause_n[4:0];
         end
         ftake_d = flush;
      end
      // Flushed value by rounding select and sign
      case (csr_d[frf_pkg::CSR_RM_LSB +: 2])
         frf_pkg::RND_PLUS: fmin_d = !OP_DONE.neg;
         frf_pkg::RND_MINUS: fmin_d = OP_DONE.neg;
         default: fmin_d = 1'b0;
      endcase
      exc_d = csr_d[frf_pkg::CSR_CAUSE_LSB + frf_pkg::EXC_E]
         || ((csr_d[frf_pkg::CSR_CAUSE_LSB +: 5] & csr_d[frf_pkg::CSR_EN_LSB +: 5])
         != 5'h0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control read port, forwards a write made in the same cycle
   logic [31:0] crd_q, crd_d;
   logic crv_q, crv_d;

   always_comb begin
      crv_d = CTL_RD_EN;
      crd_d = crd_q;
      if (CTL_RD_EN) begin
         case (CTL_RD_NUM)
            frf_pkg::CTL_NUM_ID: crd_d = id_val;
            frf_pkg::CTL_NUM_CSR: crd_d = csr_d;
            default: crd_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         csr_q <= frf_pkg::CSR_RESET;
         crd_q <= 32'h0;
         crv_q <= 1'b0;
         ftake_q <= 1'b0;
         fmin_q <= 1'b0;
         fneg_q <= 1'b0;
         exc_q <= 1'b0;
      end else begin
         csr_q <= csr_d;
         crd_q <= crd_d;
         crv_q <= crv_d;
         ftake_q <= ftake_d;
         fmin_q <= fmin_d;
         fneg_q <= fneg_d;
         exc_q <= exc_d;
      end
   end

   // Outputs straight from flops
   assign FPR_RD_DATA = rdata_q;
   assign FPR_RD_VALID = rvalid_q;
   assign FPR_RD_BAD = rbad_q;
   assign FPR_WR_BAD = fpr_wr_bad_q;
   assign CTL_RD_DATA = crd_q;
   assign CTL_RD_VALID = crv_q;
   assign ROUND_SELECT = csr_q[frf_pkg::CSR_RM_LSB +: 2];
   assign DENORM_FLUSH_ENABLE = csr_q[frf_pkg::CSR_FS_BIT];
   assign COND = csr_q[frf_pkg::CSR_COND_BIT];
   assign FP_EXC = exc_q;
   assign FLUSH_TAKE = ftake_q;
   assign FLUSH_MINNORM = fmin_q;
   assign FLUSH_NEG = fneg_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   cond_only_a: assert property (@(posedge CLK) disable iff (!RSTN)
      $changed(COND) |-> $past(CMP_EN || wr31))
      else $error("condition changed without compare or write");

   cmp_cond_a: assert property (@(posedge CLK) disable iff (!RSTN)
      CMP_EN |=> COND == $past(CMP_RESULT))
      else $error("compare result not in condition bit");

   id_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
      CTL_RD_EN && CTL_RD_NUM == 5'h00 |=> CTL_RD_VALID && CTL_RD_DATA[31:16] == 16'h0
      && CTL_RD_DATA[15:8] == IMP_CODE && CTL_RD_DATA[7:4] == REV_MAJOR)
      else $error("identification read wrong");

   rsv_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
      CTL_RD_EN && CTL_RD_NUM != 5'h00 && CTL_RD_NUM != 5'h1F |=> CTL_RD_DATA == 32'h0)
      else $error("reserved control number not zero");

   zero_bits_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (csr_q & ~frf_pkg::CSR_WR_MASK) == 32'h0)
      else $error("status zero range holds ones");

   exc_level_a: assert property (@(posedge CLK) disable iff (!RSTN)
      ##1 FP_EXC == (csr_q[17] || ((csr_q[16:12] & csr_q[11:7]) != 5'h0)))
      else $error("exception level wrong");

   flag_keep_a: assert property (@(posedge CLK) disable iff (!RSTN)
      !wr31 |=> (($past(csr_q[6:2]) & ~csr_q[6:2]) == 5'h0))
      else $error("flag cleared by hardware");

   cause_keep_a: assert property (@(posedge CLK) disable iff (!RSTN)
      !wr31 && !upd |=> $stable(csr_q[17:12]) && $stable(csr_q[6:2]))
      else $error("cause or flags changed by other class");

   flush_a: assert property (@(posedge CLK) disable iff (!RSTN)
      upd && OP_DONE.denorm && !wr31 && csr_q[24] && csr_q[10:7] ==? 4'b??00
      |=> FLUSH_TAKE && csr_q[13:12] == 2'h3)
      else $error("denormal not flushed");

   odd_bad_a: assert property (@(posedge CLK) disable iff (!RSTN)
      FPR_RD_REQ.en && !FPR_RD_REQ.word && !REG_WIDTH_SELECT && FPR_RD_REQ.num[0]
      |-> ##2 FPR_RD_BAD && FPR_RD_DATA == 64'h0)
      else $error("odd register read not refused");

   rd_after_wr_a: assert property (@(posedge CLK) disable iff (!RSTN)
      wr31 && !CMP_EN && !upd ##1 CTL_RD_EN && CTL_RD_NUM == 5'h1F && !CMP_EN && !upd
      |=> CTL_RD_DATA == ($past(CTL_WR_DATA, 2) & frf_pkg::CSR_WR_MASK))
      else $error("read after write stale");

endmodule

// ==== verilog/frf_pkg.sv ====
// Shared constants and carriers for the FP register storage and control block
package frf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Storage geometry
   localparam int unsigned FPR_NUM_W = 5;      // Register number width
   localparam int unsigned FPR_W = 64;         // Width of one storage entry
   localparam int unsigned WORD_W = 32;        // Low-half word access width
   localparam int unsigned FPR_COUNT_NARROW = 16; // Registers with width select 0
   localparam int unsigned FPR_COUNT_WIDE = 32;   // Registers with width select 1

   ////////////////////////////////////////////////////////////////////////////
   // Control register numbers
   localparam logic [4:0] CTL_NUM_ID = 5'h00;    // Identification
   localparam logic [4:0] CTL_NUM_CSR = 5'h1F;   // Control/status

   ////////////////////////////////////////////////////////////////////////////
   // Control/status field positions
   localparam int unsigned CSR_FS_BIT = 24;     // Denormal flush enable
   localparam int unsigned CSR_COND_BIT = 23;   // Compare condition
   localparam int unsigned CSR_CAUSE_LSB = 12;  // Cause E V Z O U I
   localparam int unsigned CSR_EN_LSB = 7;      // Enables V Z O U I
   localparam int unsigned CSR_FLAG_LSB = 2;    // Flags V Z O U I
   localparam int unsigned CSR_RM_LSB = 0;      // Rounding select
   localparam logic [31:0] CSR_WR_MASK = 32'h0183FFFF; // Bits that exist, 31:25 and 22:18 stay zero
   localparam logic [31:0] CSR_RESET = 32'h00000000;   // Value after reset

   // Exception bit positions within a five-bit field, E is bit 5 of cause
   localparam int unsigned EXC_I = 0;
   localparam int unsigned EXC_U = 1;
   localparam int unsigned EXC_E = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Rounding select encodings
   localparam logic [1:0] RND_NEAREST = 2'h0;
   localparam logic [1:0] RND_ZERO = 2'h1;
   localparam logic [1:0] RND_PLUS = 2'h2;
   localparam logic [1:0] RND_MINUS = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Identification fields
   localparam int unsigned ID_IMP_LSB = 8;
   localparam int unsigned ID_MAJ_LSB = 4;
   localparam int unsigned ID_MIN_LSB = 0;

   // Instruction class reported with each finished operation
   typedef enum logic [2:0] {
      FRF_OP_NONE,
      FRF_OP_COPY,
      FRF_OP_COMPUTE,
      FRF_OP_CONVERT,
      FRF_OP_RESERVED
   } frf_op_class_t;

   // Result report of one finished operation
   typedef struct packed {
      frf_op_class_t op_class;
      logic [5:0] cause;   // E V Z O U I raised by the operation
      logic denorm;        // Result is denormal
      logic neg;           // Sign of that result
   } frf_op_t;

   // Storage access request
   typedef struct packed {
      logic en;
      logic [4:0] num;
      logic word;          // 1: 32-bit general storage access
   } frf_req_t;

endpackage

// ==== verilog/frf_store.sv ====
`timescale 1ns/1ps
// One bank of general storage, two half-word write enables, registered read
module frf_store #(
   parameter int unsigned DEPTH = 16,
   parameter int unsigned AW = 4,
   parameter int unsigned W = 64
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [1:0] wr_half,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data_q
);

   logic [W-1:0] mem [DEPTH]; // Storage array, no reset on purpose
   logic [W-1:0] rd_data_d;

   // Read port, a write in the same cycle returns the old contents
   always_comb begin
      rd_data_d = rd_data_q;
      if (rd_en) begin
         rd_data_d = mem[rd_addr];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   // Half-word writes, low half for word moves
   always_ff @(posedge clk) begin
      if (wr_half[0]) begin
         mem[wr_addr][W/2-1:0] <= wr_data[W/2-1:0];
      end
      if (wr_half[1]) begin
         mem[wr_addr][W-1:W/2] <= wr_data[W-1:W/2];
      end
   end

endmodule

// ==== verif/frf_cpu_model.sv ====
`timescale 1ns/1ps
// CPU side model: issues storage, control and result traffic one at a time
module frf_cpu_model (
   input wire logic clk,
   input wire logic [63:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_bad,
   input wire logic wr_bad,
   input wire logic [31:0] c_rd_data,
   input wire logic c_rd_valid,
   input wire logic [2:0] fl,
   output frf_pkg::frf_req_t rd_req,
   output frf_pkg::frf_req_t wr_req,
   output logic [63:0] wr_data,
   output logic c_rd_en,
   output logic [4:0] c_num,
   output logic c_wr_en,
   output logic [31:0] c_wr_data,
   output logic cmp_en,
   output logic cmp_res,
   output frf_pkg::frf_op_t op
);
   logic [63:0] got64; // Last storage answer
   logic got_bad; // Refusal seen with it
   logic [31:0] got32; // Last control answer
   logic [31:0] got32b; // Control answer one cycle behind a write
   logic [2:0] got_fl; // Flush take, min normal, sign
   int n; // Bounded wait count

   ////////////////////////////////////////////////////////////////////////////
   // Quiet lines from time zero
   initial begin
      {rd_req, wr_req, wr_data, c_rd_en, c_num, c_wr_en, c_wr_data, cmp_en, cmp_res, op} = '0;
   end

   // Control access, how[1] writes, how[0] reads in that cycle and again right after a write
   task automatic ctl(input logic [4:0] num, input logic [31:0] d, input logic [1:0] how);
      @(posedge clk);
      c_wr_en <= how[1];
      c_rd_en <= how[0];
      c_num <= num;
      c_wr_data <= d;
      @(posedge clk);
      c_wr_en <= 1'b0;
      c_rd_en <= &how; // Back-to-back read behind the write
      c_wr_data <= ~d; // Released data must not look valid
      @(posedge clk);
      c_rd_en <= 1'b0;
      got32 = (c_rd_valid === 1'b1) ? c_rd_data : 32'hXXXXXXXX;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (how[1] && how[0] && c_rd_valid !== 1'b1 && n < 4);
      got32b = (c_rd_valid === 1'b1) ? c_rd_data : 32'hXXXXXXXX;
   endtask

   // Storage write; refusal shows one cycle after the taking edge
   task automatic fpr_wr(input logic [4:0] num, input logic word, input logic [63:0] d);
      @(posedge clk);
      wr_req <= {1'b1, num, word};
      wr_data <= d;
      @(posedge clk);
      wr_req.en <= 1'b0;
      wr_data <= ~d;
      @(posedge clk);
      got_bad = wr_bad;
   endtask

   // Storage read; a missing answer reads as unknown
   task automatic fpr_rd(input logic [4:0] num, input logic word);
      @(posedge clk);
      rd_req <= {1'b1, num, word};
      @(posedge clk);
      rd_req.en <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rd_valid !== 1'b1 && n < 4);
      got64 = (rd_valid === 1'b1) ? rd_data : 64'hXXXXXXXXXXXXXXXX;
      got_bad = rd_bad;
   endtask

   // One finished operation and or compare, flush outputs caught a cycle on
   task automatic report(input frf_pkg::frf_op_t o, input logic ce, input logic cr);
      @(posedge clk);
      op <= o;
      cmp_en <= ce;
      cmp_res <= cr;
      @(posedge clk);
      op <= '0;
      cmp_en <= 1'b0;
      @(posedge clk);
      got_fl = fl;
   endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
// Self-checking bench: CPU model traffic against a reference register state
module testbench;
   localparam logic [7:0] IMP = 8'h3C; // Arbitrary value
   localparam logic [3:0] MAJ = 4'h2;
   localparam logic [3:0] MIN = 4'h7;
   localparam logic [31:0] LIVE = 32'h0183FFFF; // Status bits that hold data

   logic clk, rstn, width; // Clock, reset, register width select
   frf_pkg::frf_req_t rd_req, wr_req;
   frf_pkg::frf_op_t op;
   logic [63:0] rd_data, wr_data, d;
   logic [31:0] c_rd_data, c_wr_data, csr; // Csr is the reference status
   logic [4:0] c_num;
   logic [1:0] rsel;
   logic rd_valid, rd_bad, wr_bad, c_rd_en, c_rd_valid, c_wr_en, cmp_en, cmp_res;
   logic fs, cond, exc, fl_take, fl_min, fl_neg;
   int num_errors, comparisons, cycles, seed, k;
   logic [63:0] mem [32]; // Reference storage entries
   frf_pkg::frf_op_class_t cls [3] = '{frf_pkg::FRF_OP_COMPUTE, frf_pkg::FRF_OP_CONVERT,
                                      frf_pkg::FRF_OP_RESERVED};
   logic [5:0] cz [3] = '{6'h10, 6'h04, 6'h20}; // Causes V, O, then E

   frf_top #(.IMP_CODE(IMP), .REV_MAJOR(MAJ), .REV_MINOR(MIN)) DUT (
      .CLK(clk), .RSTN(rstn), .REG_WIDTH_SELECT(width),
      .FPR_RD_REQ(rd_req), .FPR_RD_DATA(rd_data), .FPR_RD_VALID(rd_valid), .FPR_RD_BAD(rd_bad),
      .FPR_WR_REQ(wr_req), .FPR_WR_DATA(wr_data), .FPR_WR_BAD(wr_bad),
      .CTL_RD_EN(c_rd_en), .CTL_RD_NUM(c_num), .CTL_RD_DATA(c_rd_data),
      .CTL_RD_VALID(c_rd_valid), .CTL_WR_EN(c_wr_en), .CTL_WR_NUM(c_num),
      .CTL_WR_DATA(c_wr_data), .CMP_EN(cmp_en), .CMP_RESULT(cmp_res), .OP_DONE(op),
      .ROUND_SELECT(rsel), .DENORM_FLUSH_ENABLE(fs), .COND(cond), .FP_EXC(exc),
      .FLUSH_TAKE(fl_take), .FLUSH_MINNORM(fl_min), .FLUSH_NEG(fl_neg));

   frf_cpu_model cpu (
      .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_bad(rd_bad), .wr_bad(wr_bad),
      .c_rd_data(c_rd_data), .c_rd_valid(c_rd_valid), .fl({fl_take, fl_min, fl_neg}),
      .rd_req(rd_req), .wr_req(wr_req), .wr_data(wr_data), .c_rd_en(c_rd_en), .c_num(c_num),
      .c_wr_en(c_wr_en), .c_wr_data(c_wr_data), .cmp_en(cmp_en), .cmp_res(cmp_res), .op(op));

   ////////////////////////////////////////////////////////////////////////////
   // Comparison and closing
   task automatic chk_fpr(input logic [63:0] got, input logic [63:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_ctl(input logic [31:0] got, input logic [31:0] exp, input string what);
      chk_fpr({32'h00000000, got}, {32'h00000000, exp}, what);
   endtask

   task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp, input string what);
      chk_fpr({60'h0, got}, {60'h0, exp}, what);
   endtask

   task automatic give_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reference model
   // Exception level: unimplemented cause, or any cause with its enable
   function automatic logic exc_of(input logic [31:0] c);
      return c[17] | (|(c[16:12] & c[11:7]));
   endfunction

   // Cause is replaced; flags gather only when the result is not trapped
   function automatic logic [31:0] apply(input logic [31:0] c, input logic [5:0] cause);
      logic trap;
      trap = cause[5] | (|(cause[4:0] & c[11:7]));
      c[17:12] = cause;
      if (!trap)
         c[6:2] = c[6:2] | cause[4:0];
      return c;
   endfunction

   // Read status back, then its decoded outputs once settled
   task automatic chk_csr();
      cpu.ctl(5'h1F, 32'h00000000, 2'h1);
      #1;
      chk_ctl(cpu.got32, csr, "status");
      chk_bits({fs, cond, rsel}, {csr[24], csr[23], csr[1:0]}, "status pins");
      chk_bits({3'h0, exc}, {3'h0, exc_of(csr)}, "exception");
   endtask

   // Whole wide-mode readback against the reference
   task automatic wide_check();
      for (k = 0; k < 32; k++) begin
         cpu.fpr_rd(k[4:0], 1'b0);
         chk_fpr(cpu.got64, mem[k], "wide read");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; a few thousand cycles is ample for this run
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 71;
      rstn = 1'b0;
      width = 1'b1;
      csr = 32'h00000000;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      // Identification ignores writes; reserved numbers read zero
      cpu.ctl(5'h00, 32'hFFFFFFFF, 2'h3);
      chk_ctl(cpu.got32, {16'h0000, IMP, MAJ, MIN}, "id");
      for (k = 1; k < 31; k++) begin
         cpu.ctl(k[4:0], $random(seed), 2'h3);
         chk_ctl(cpu.got32, 32'h00000000, "reserved");
      end
      chk_csr();
      $display("test control map done");
      // Every rounding code, read back in the writing cycle
      for (k = 0; k < 4; k++) begin
         d[31:0] = $random(seed);
         d[1:0] = k[1:0];
         csr = d[31:0] & LIVE;
         cpu.ctl(5'h1F, d[31:0], 2'h3);
         chk_ctl(cpu.got32, csr, "status write");
         chk_ctl(cpu.got32b, csr, "status reread");
         chk_csr();
      end
      // Compare moves the condition; a copy touches nothing
      for (k = 0; k < 4; k++) begin
         cpu.report('0, 1'b1, k[0]);
         csr[23] = k[0];
         cpu.report({frf_pkg::FRF_OP_COPY, 6'h3F, 2'h0}, 1'b0, 1'b0);
         chk_csr();
      end
      $display("test status done");
      // Result classes with no enables: cause replaced, flags gathered
      csr = 32'h00000000;
      cpu.ctl(5'h1F, csr, 2'h2);
      for (k = 0; k < 3; k++) begin
         cpu.report({cls[k], cz[k], 2'h0}, 1'b0, 1'b0);
         csr = apply(csr, cz[k]);
         chk_csr();
      end
      // Flush under each rounding code and sign, then with flushing off: emulation cause
      for (k = 0; k < 16; k++) begin
         csr = (k[3] ? 32'h00000000 : 32'h01000000) | k[1:0];
         cpu.ctl(5'h1F, csr, 2'h2);
         cpu.report({frf_pkg::FRF_OP_COMPUTE, 6'h00, 1'b1, k[2]}, 1'b0, 1'b0);
         d[0] = (k[1:0] == 2'h2 && !k[2]) || (k[1:0] == 2'h3 && k[2]);
         chk_bits({1'b0, cpu.got_fl}, {1'b0, !k[3], d[0], k[2]}, "flush");
         csr = apply(csr, k[3] ? 6'h20 : 6'h03);
         chk_csr();
      end
      $display("test results done");
      // Wide mode fill, then narrow pairs over the low halves
      for (k = 0; k < 32; k++) begin
         mem[k] = {$random(seed), $random(seed)};
         cpu.fpr_wr(k[4:0], 1'b0, mem[k]);
      end
      wide_check();
      width <= 1'b0;
      for (k = 0; k < 32; k += 2) begin
         d = {$random(seed), $random(seed)};
         mem[k][31:0] = d[31:0];
         mem[k + 1][31:0] = d[63:32];
         cpu.fpr_wr(k[4:0], 1'b0, d);
         chk_bits({3'h0, cpu.got_bad}, 4'h0, "pair write");
         cpu.fpr_rd(k[4:0], 1'b0);
         chk_fpr(cpu.got64, {mem[k + 1][31:0], mem[k][31:0]}, "pair read");
         cpu.fpr_rd(k[4:0] + 5'h01, 1'b0);
         chk_fpr(cpu.got64, 64'h0, "odd read data");
         chk_bits({3'h0, cpu.got_bad}, 4'h1, "odd read");
      end
      // Odd number 3 refused; a word access to odd number 5 is not
      d = {$random(seed), $random(seed)};
      cpu.fpr_wr(5'h03, 1'b0, d);
      chk_bits({3'h0, cpu.got_bad}, 4'h1, "odd write");
      cpu.fpr_wr(5'h05, 1'b1, d);
      mem[5][31:0] = d[31:0];
      cpu.fpr_rd(5'h05, 1'b1);
      chk_fpr(cpu.got64, {32'h00000000, d[31:0]}, "word read");
      width <= 1'b1;
      wide_check();
      $display("test storage done");
      give_verdict();
   end
endmodule
